// [rtl/iod_regs.svh]
// Address map, bit masks and reset values for the peripheral I/O decoder.
// Assumes I/O addresses are 6 bits and data-space addresses 9 bits wide.
`ifndef IOD_REGS_SVH
`define IOD_REGS_SVH

// Address windows and register reset value
`define IOD_DATA_OFFSET   9'h020
`define IOD_IO_LAST       9'h05F
`define IOD_EXT_FIRST     9'h060
`define IOD_EXT_LAST      9'h1FF
`define IOD_BIT_LAST      6'h1F
`define IOD_RESET_VALUE   8'h00

// Register offsets, data-space addresses
`define IOD_PORT_B_OUTPUT_PIN     9'h023
`define IOD_PORT_B_OUTPUT_DIR     9'h024
`define IOD_PORT_B_OUTPUT_OUT     9'h025
`define IOD_PORT_C_OUTPUT_PIN     9'h026
`define IOD_PORT_C_OUTPUT_DIR     9'h027
`define IOD_PORT_C_OUTPUT_OUT     9'h028
`define IOD_PORT_D_OUTPUT_PIN     9'h029
`define IOD_PORT_D_OUTPUT_DIR     9'h02A
`define IOD_PORT_D_OUTPUT_OUT     9'h02B
`define IOD_PORT_E_OUTPUT_PIN     9'h02C
`define IOD_PORT_E_OUTPUT_DIR     9'h02D
`define IOD_PORT_E_OUTPUT_OUT     9'h02E
`define IOD_PORT_F_OUTPUT_PIN     9'h02F
`define IOD_PORT_F_OUTPUT_DIR     9'h030
`define IOD_PORT_F_OUTPUT_OUT     9'h031
`define IOD_TMR0_FLAGS    9'h035
`define IOD_TMR1_FLAGS    9'h036
`define IOD_TMR4_FLAGS    9'h039
`define IOD_PCHG_FLAGS    9'h03B
`define IOD_EXTIRQ_FLAGS  9'h03C
`define IOD_EXTIRQ_MASK   9'h03D
`define IOD_SCRATCH0      9'h03E
`define IOD_NV_CTRL       9'h03F
`define IOD_NV_DATA       9'h040
`define IOD_NV_ADDR_LO    9'h041
`define IOD_NV_ADDR_HI    9'h042
`define IOD_PRESC_CTRL    9'h043
`define IOD_TMR0_CTRL_A   9'h044
`define IOD_TMR0_CTRL_B   9'h045
`define IOD_TMR0_COUNT    9'h046
`define IOD_TMR0_CMP_A    9'h047
`define IOD_TMR0_CMP_B    9'h048
`define IOD_PLL_CSR       9'h049
`define IOD_SCRATCH1      9'h04A
`define IOD_SCRATCH2      9'h04B
`define IOD_SPI_CTRL      9'h04C
`define IOD_SPI_STAT      9'h04D
`define IOD_SPI_DATA      9'h04E
`define IOD_COMP_CSR      9'h050
`define IOD_DBG_DATA      9'h051
`define IOD_PLL_FREQ      9'h052
`define IOD_SLEEP_CTRL    9'h053
`define IOD_RST_CAUSE     9'h054
`define IOD_CORE_CTRL     9'h055
`define IOD_SELFPROG_CTRL 9'h057
`define IOD_FAR_PAGE      9'h05B
`define IOD_STACK_LO      9'h05D
`define IOD_STACK_HI      9'h05E

// Implemented-bit, hardware-followed and clear-on-one bit masks for registers
`define IOD_MASK_FULL     8'hFF
`define IOD_MASK_NONE     8'h00
`define IOD_MASK_PORT_C_OUTPUT    8'hC0
`define IOD_MASK_PORT_E_OUTPUT    8'h44
`define IOD_MASK_PORT_F_OUTPUT    8'hF3
`define IOD_MASK_TMR0F    8'h07
`define IOD_MASK_TMR1F    8'h2F
`define IOD_MASK_TMR4F    8'hE4
`define IOD_MASK_PCHGF    8'h01
`define IOD_MASK_EXTIRQ   8'h4F
`define IOD_MASK_NVCTRL   8'h3F
`define IOD_MASK_NVADRHI  8'h0F
`define IOD_MASK_PRESC    8'h83
`define IOD_MASK_TMR0A    8'hF3
`define IOD_MASK_TMR0B    8'hCF
`define IOD_MASK_PLL_CONTROL_STATUS   8'h13
`define IOD_HW_PLL_CONTROL_STATUS     8'h01
`define IOD_MASK_SPISTAT  8'hC1
`define IOD_HW_SPISTAT    8'hC0
`define IOD_HW_COMP       8'h20
`define IOD_W1C_COMP      8'h10
`define IOD_MASK_SLEEP    8'h0F
`define IOD_MASK_RSTCAUSE 8'h3F
`define IOD_MASK_CORECTRL 8'h93
`define IOD_MASK_FARPAGE  8'h03

`endif

// [rtl/iod_pkg.sv]
// Types shared by the peripheral I/O decoder and its surroundings.
// Assumes the constants of iod_regs.svh for widths of the address fields.
package iod_pkg;

    typedef enum logic [7:0] {
        IOD_OP_IN      = 8'h01,   // I/O-space read
        IOD_OP_OUT     = 8'h02,   // I/O-space write
        IOD_OP_SETBIT  = 8'h04,   // set_io_bit_op
        IOD_OP_CLRBIT  = 8'h08,   // clear_io_bit_op
        IOD_OP_SKIPSET = 8'h10,   // skip_if_io_bit_set_op
        IOD_OP_SKIPCLR = 8'h20,   // skip_if_io_bit_clear_op
        IOD_OP_LOAD    = 8'h40,   // direct, indirect or displaced load
        IOD_OP_STORE   = 8'h80    // direct, indirect or displaced store
    } iod_op_t;

    typedef enum logic [1:0] {
        IOD_ST_IDLE    = 2'h1,
        IOD_ST_EXTWAIT = 2'h2
    } iod_state_t;

    typedef struct packed {
        logic       valid;
        iod_op_t    op;
        logic [8:0] addr;     // I/O address in [5:0] for I/O ops, data address otherwise
        logic [2:0] bitSel;
        logic [7:0] wdata;
    } iod_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
        logic       bitVal;
        logic       skip;
        logic       refused;
    } iod_resp_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [8:0] addr;
        logic [7:0] wdata;
    } iod_ext_t;

    typedef struct packed {
        logic [7:0] impl;     // implemented bits
        logic [7:0] w1c;      // cleared by writing one
        logic [7:0] hw;       // read-only, followed from hardware
    } iod_attr_t;

endpackage

// [rtl/iod_decoder.sv]
// Peripheral I/O space decoder: core accesses in, register bank and extended-space strobes out.
// Assumes one request per accepted cycle from the core and peripherals synchronous to clk.
//
// What this block does
// - Registers at I/O addresses 0x00 to 0x1F accept a set or clear of one chosen bit.
// - In that bit-accessible range the value of one selected bit is returned for a skip.
// - Some status flags clear when a one is written to them and ignore a written zero.
// - A single-bit set or clear rewrites the whole register, so flags read as set get cleared.
// - Single-bit set and clear act only on I/O addresses 0x00 to 0x1F and nowhere else.
// - I/O read and write operations address registers by I/O addresses 0x00 to 0x3F.
// - A data-space load or store reaches the same register at its I/O address plus 0x20.
// - The I/O operation address field covers exactly 64 locations and nothing beyond.
// - The extended space 0x60 to 0x1FF is reached only by data-space loads and stores.

`timescale 1ns/1ns

`include "iod_regs.svh"

module iod_decoder
    import iod_pkg::*;
#(
    parameter int IO_LOCATIONS = 64
)
(
    input  wire logic            clk,        // core clock
    input  wire logic            rst,        // synchronous reset, active high
    input  wire iod_req_t        req,        // access request from the core
    output logic                 reqReady,   // request is taken while high
    output iod_resp_t            resp,       // one-cycle answer
    input  wire logic [63:0][7:0] hwIn,      // live status bits from peripherals
    input  wire logic [63:0][7:0] hwSet,     // one-cycle flag set events
    output logic [63:0][7:0]     ioRegs,     // register bank, indexed by I/O address
    output iod_ext_t             ext,        // extended-space access strobe
    input  wire logic [7:0]      extRdData   // extended-space read data, valid with ext strobe
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register attributes

    function automatic iod_attr_t attrOf(input logic [8:0] dataAddr);
        iod_attr_t a;
        a = '{impl: `IOD_MASK_NONE, w1c: `IOD_MASK_NONE, hw: `IOD_MASK_NONE};
        // Unlisted locations stay all-zero masks, so they read zero and ignore writes
        case (dataAddr)
            `IOD_PORT_B_OUTPUT_PIN, `IOD_PORT_D_OUTPUT_PIN:
                a = '{impl: `IOD_MASK_FULL, w1c: `IOD_MASK_NONE, hw: `IOD_MASK_FULL};
            `IOD_PORT_C_OUTPUT_PIN:
                a = '{impl: `IOD_MASK_PORT_C_OUTPUT, w1c: `IOD_MASK_NONE, hw: `IOD_MASK_PORT_C_OUTPUT};
            `IOD_PORT_E_OUTPUT_PIN:
                a = '{impl: `IOD_MASK_PORT_E_OUTPUT, w1c: `IOD_MASK_NONE, hw: `IOD_MASK_PORT_E_OUTPUT};
            `IOD_PORT_F_OUTPUT_PIN:
                a = '{impl: `IOD_MASK_PORT_F_OUTPUT, w1c: `IOD_MASK_NONE, hw: `IOD_MASK_PORT_F_OUTPUT};
            `IOD_PORT_C_OUTPUT_DIR, `IOD_PORT_C_OUTPUT_OUT:
                a.impl = `IOD_MASK_PORT_C_OUTPUT;
            `IOD_PORT_E_OUTPUT_DIR, `IOD_PORT_E_OUTPUT_OUT:
                a.impl = `IOD_MASK_PORT_E_OUTPUT;
            `IOD_PORT_F_OUTPUT_DIR, `IOD_PORT_F_OUTPUT_OUT:
                a.impl = `IOD_MASK_PORT_F_OUTPUT;
            `IOD_TMR0_FLAGS:
                a = '{impl: `IOD_MASK_TMR0F, w1c: `IOD_MASK_TMR0F, hw: `IOD_MASK_NONE};
            `IOD_TMR1_FLAGS:
                a = '{impl: `IOD_MASK_TMR1F, w1c: `IOD_MASK_TMR1F, hw: `IOD_MASK_NONE};
            `IOD_TMR4_FLAGS:
                a = '{impl: `IOD_MASK_TMR4F, w1c: `IOD_MASK_TMR4F, hw: `IOD_MASK_NONE};
            `IOD_PCHG_FLAGS:
                a = '{impl: `IOD_MASK_PCHGF, w1c: `IOD_MASK_PCHGF, hw: `IOD_MASK_NONE};
            `IOD_EXTIRQ_FLAGS:
                a = '{impl: `IOD_MASK_EXTIRQ, w1c: `IOD_MASK_EXTIRQ, hw: `IOD_MASK_NONE};
            `IOD_EXTIRQ_MASK:
                a.impl = `IOD_MASK_EXTIRQ;
            `IOD_NV_CTRL:
                a.impl = `IOD_MASK_NVCTRL;
            `IOD_NV_ADDR_HI:
                a.impl = `IOD_MASK_NVADRHI;
            `IOD_PRESC_CTRL:
                a.impl = `IOD_MASK_PRESC;
            `IOD_TMR0_CTRL_A:
                a.impl = `IOD_MASK_TMR0A;
            `IOD_TMR0_CTRL_B:
                a.impl = `IOD_MASK_TMR0B;
            `IOD_PLL_CSR:
                a = '{impl: `IOD_MASK_PLL_CONTROL_STATUS, w1c: `IOD_MASK_NONE, hw: `IOD_HW_PLL_CONTROL_STATUS};
            `IOD_SPI_STAT:
                a = '{impl: `IOD_MASK_SPISTAT, w1c: `IOD_MASK_NONE, hw: `IOD_HW_SPISTAT};
            `IOD_COMP_CSR:
                a = '{impl: `IOD_MASK_FULL, w1c: `IOD_W1C_COMP, hw: `IOD_HW_COMP};
            `IOD_SLEEP_CTRL:
                a.impl = `IOD_MASK_SLEEP;
            `IOD_RST_CAUSE:
                a.impl = `IOD_MASK_RSTCAUSE;
            `IOD_CORE_CTRL:
                a.impl = `IOD_MASK_CORECTRL;
            `IOD_FAR_PAGE:
                a.impl = `IOD_MASK_FARPAGE;
            `IOD_PORT_B_OUTPUT_DIR, `IOD_PORT_B_OUTPUT_OUT, `IOD_PORT_D_OUTPUT_DIR, `IOD_PORT_D_OUTPUT_OUT,
            `IOD_SCRATCH0, `IOD_SCRATCH1, `IOD_SCRATCH2, `IOD_NV_DATA,
            `IOD_NV_ADDR_LO, `IOD_TMR0_COUNT, `IOD_TMR0_CMP_A, `IOD_TMR0_CMP_B,
            `IOD_SPI_CTRL, `IOD_SPI_DATA, `IOD_DBG_DATA, `IOD_PLL_FREQ,
            `IOD_SELFPROG_CTRL, `IOD_STACK_LO, `IOD_STACK_HI:
                a.impl = `IOD_MASK_FULL;
            default:
                a.impl = `IOD_MASK_NONE;
        endcase
        return a;
    endfunction

    // Next value of one location: plain bits take the write, flag bits clear on one, live bits follow hardware
    function automatic logic [7:0] nextByte(input logic [7:0] cur,
                                            input iod_attr_t a,
                                            input logic      wr,
                                            input logic [7:0] wd,
                                            input logic [7:0] hwVal,
                                            input logic [7:0] setVal);
        logic [7:0] plain;
        logic [7:0] clr;
        plain = a.impl & ~a.w1c & ~a.hw;
        clr   = wr ? wd : 8'h00;
        // Set event wins over a same-cycle clear, so no flag is lost
        return ((wr ? wd : cur) & plain)
             | (((cur & ~clr) | setVal) & a.w1c)
             | (hwVal & a.hw);
    endfunction

    function automatic logic [8:0] dataOf(input logic [5:0] ioAddr);
        return {3'h0, ioAddr} + `IOD_DATA_OFFSET;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Request decode

    iod_state_t state;
    iod_state_t next_state;

    wire logic       accept   = req.valid && reqReady;
    wire logic       isIoOp   = req.op inside {IOD_OP_IN, IOD_OP_OUT, IOD_OP_SETBIT,
                                               IOD_OP_CLRBIT, IOD_OP_SKIPSET, IOD_OP_SKIPCLR};
    wire logic       isBitOp  = req.op inside {IOD_OP_SETBIT, IOD_OP_CLRBIT,
                                               IOD_OP_SKIPSET, IOD_OP_SKIPCLR};
    wire logic       isDataOp = req.op inside {IOD_OP_LOAD, IOD_OP_STORE};
    wire logic       isWrite  = req.op inside {IOD_OP_OUT, IOD_OP_STORE,
                                               IOD_OP_SETBIT, IOD_OP_CLRBIT};

    // The opcode field carries six bits, so only 64 locations are reachable
    wire logic [5:0] ioField  = req.addr[5:0];
    // A data address maps onto the same location 0x20 lower
    wire logic [8:0] dataAddr = isIoOp ? dataOf(ioField) : req.addr;
    wire logic       inIoWin  = (dataAddr >= `IOD_DATA_OFFSET) && (dataAddr <= `IOD_IO_LAST);
    wire logic [8:0] ioOffs   = dataAddr - `IOD_DATA_OFFSET;
    wire logic [5:0] ioIdx    = ioOffs[5:0];

    // Extended space is only for loads and stores; I/O ops can never form such an address
    wire logic       extHit   = isDataOp && (dataAddr >= `IOD_EXT_FIRST) && (dataAddr <= `IOD_EXT_LAST);
    wire logic       bitOk    = ioIdx <= `IOD_BIT_LAST;
    wire logic       legal    = isBitOp ? (inIoWin && bitOk) : (inIoWin || extHit);

    wire iod_attr_t  curAttr  = attrOf(dataAddr);
    wire logic [7:0] curVal   = ioRegs[ioIdx] & curAttr.impl;
    wire logic [7:0] bitMask  = 8'h01 << req.bitSel;
    wire logic       selBit   = curVal[req.bitSel];

    // Bit ops write back the whole byte as read, so set flags go back as ones
    wire logic [7:0] wrData   = (req.op == IOD_OP_SETBIT) ? (curVal | bitMask)
                              : (req.op == IOD_OP_CLRBIT) ? (curVal & ~bitMask)
                              : req.wdata;
    wire logic       doIoWr   = accept && isWrite && legal && inIoWin;
    wire logic       doExt    = accept && legal && extHit;
    wire logic       extRead  = doExt && (req.op == IOD_OP_LOAD);

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state values

    logic [63:0][7:0] next_ioRegs;
    iod_resp_t        next_resp;
    iod_ext_t         next_ext;

    always_comb
    begin
        for (int i = 0; i < IO_LOCATIONS; i++)
        begin
            next_ioRegs[i] = nextByte(ioRegs[i], attrOf(dataOf(6'(i))),
                                      doIoWr && (ioIdx == 6'(i)), wrData, hwIn[i], hwSet[i]);
        end
    end

    always_comb
    begin
        next_resp         = '0;
        next_resp.valid   = accept && !extRead;
        next_resp.refused = accept && !legal;
        if (state == IOD_ST_EXTWAIT)
        begin
            next_resp.valid = 1'b1;
            next_resp.rdata = extRdData;
        end
        else if (accept && legal && !extHit)
        begin
            next_resp.rdata  = curVal;
            next_resp.bitVal = isBitOp && selBit;
            next_resp.skip   = ((req.op == IOD_OP_SKIPSET) && selBit)
                            || ((req.op == IOD_OP_SKIPCLR) && !selBit);
        end
    end

    always_comb
    begin
        next_ext       = '0;
        next_ext.valid = doExt;
        if (doExt)
        begin
            next_ext.write = req.op == IOD_OP_STORE;
            next_ext.addr  = dataAddr;
            next_ext.wdata = req.wdata;
        end
    end

    // A single wait state covers the extended read; the core is stalled for it
    always_comb
    begin
        unique case (state)
            IOD_ST_IDLE:    next_state = extRead ? IOD_ST_EXTWAIT : IOD_ST_IDLE;
            IOD_ST_EXTWAIT: next_state = IOD_ST_IDLE;
            default:        next_state = IOD_ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State

    always_ff @(posedge clk)
    begin
        if (rst)
            ioRegs <= {IO_LOCATIONS{`IOD_RESET_VALUE}};
        else
            ioRegs <= next_ioRegs;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state    <= IOD_ST_IDLE;
            reqReady <= 1'b0;
            resp     <= '0;
            ext      <= '0;
        end
        else
        begin
            state    <= next_state;
            reqReady <= next_state == IOD_ST_IDLE;
            resp     <= next_resp;
            ext      <= next_ext;
        end
    end

endmodule

// [tb/iod_ext_model.sv]
// Far-side model of the extended I/O space behind the decoder's strobe port.
// Assumes one strobe per access and read data sampled at the edge that ends the strobe cycle.
`timescale 1ns/1ns
module iod_ext_model
    import iod_pkg::*;
(
    input  wire logic     clk,       // core clock
    input  wire iod_ext_t ext,       // access strobe from the decoder
    output logic [7:0]    extRdData  // read data, driven within the strobe cycle
);
    logic [7:0] mem [logic [8:0]];

    initial extRdData = 8'h00;

    // Only data-space loads and stores ever arrive here
    always @(negedge clk)
        if (ext.valid === 1'b1 && ext.write === 1'b1)
            mem[ext.addr] = ext.wdata;
        else if (ext.valid === 1'b1)
            extRdData <= mem.exists(ext.addr) ? mem[ext.addr] : ext.addr[7:0] ^ 8'h5A;
        else
            extRdData <= ~extRdData;  // Released bus must not keep the last value
endmodule

// [tb/iod_decoder_monitor.sv]
// Assertion checker for the I/O space decoder, seeing only its ports.
// Assumes a single clock and the synchronous active-high reset.
`timescale 1ns/1ns
module iod_decoder_monitor
    import iod_pkg::*;
#(
    parameter int IO_LOCATIONS = 64
)
(
    input wire logic             clk,       // core clock
    input wire logic             rst,       // synchronous reset
    input wire iod_req_t         req,       // core request
    input wire logic             reqReady,  // request taken
    input wire iod_resp_t        resp,      // answer
    input wire logic [63:0][7:0] hwIn,      // live status
    input wire logic [63:0][7:0] hwSet,     // flag set events
    input wire logic [63:0][7:0] ioRegs,    // register bank
    input wire iod_ext_t         ext,       // extended strobe
    input wire logic [7:0]       extRdData  // extended read data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    wire       taken    = req.valid && reqReady;
    wire [5:0] ioAddr   = req.addr[5:0];
    wire [5:0] aliasIdx = req.addr[5:0] - 6'h20;
    wire       dataOp   = req.op == IOD_OP_LOAD || req.op == IOD_OP_STORE;
    wire       bitOp    = req.op == IOD_OP_SETBIT || req.op == IOD_OP_CLRBIT;
    // Full read-write registers only, so hardware-followed bits cannot disturb the check
    wire       plainReg = ioAddr == 6'h04 || ioAddr == 6'h05 || ioAddr == 6'h0A || ioAddr == 6'h0B;

    AST_SET_BIT: assert property (taken && req.op == IOD_OP_SETBIT && plainReg |=>
        ioRegs[$past(ioAddr)] == ($past(ioRegs[ioAddr]) | (8'h01 << $past(req.bitSel))))
        else $error("single-bit set wrong");
    AST_CLR_BIT: assert property (taken && req.op == IOD_OP_CLRBIT && plainReg |=>
        ioRegs[$past(ioAddr)] == ($past(ioRegs[ioAddr]) & ~(8'h01 << $past(req.bitSel))))
        else $error("single-bit clear wrong");
    AST_SKIP_BIT: assert property (taken && (req.op == IOD_OP_SKIPSET || req.op == IOD_OP_SKIPCLR)
        && ioAddr <= 6'h1F |=> resp.valid && resp.bitVal == $past(ioRegs[ioAddr][req.bitSel])
        && resp.skip == ($past(ioRegs[ioAddr][req.bitSel]) == $past(req.op == IOD_OP_SKIPSET)))
        else $error("bit test answer wrong");
    AST_FLAG_W1C: assert property (taken && req.op == IOD_OP_OUT && ioAddr == 6'h15
        && hwSet[21] == 8'h00 |=> ioRegs[21] == ($past(ioRegs[21]) & ~$past(req.wdata)))
        else $error("flag clear by one wrong");
    AST_BIT_RANGE: assert property (taken && bitOp && ioAddr > 6'h1F |=>
        resp.valid && resp.refused && !ext.valid)
        else $error("bit op above 0x1F not refused");
    AST_IO_READ: assert property (taken && req.op == IOD_OP_IN |=>
        resp.valid && !resp.refused && resp.rdata == $past(ioRegs[ioAddr]))
        else $error("I/O read data wrong");
    AST_DATA_ALIAS: assert property (taken && req.op == IOD_OP_LOAD && req.addr >= 9'h020
        && req.addr <= 9'h05F |=> resp.valid && resp.rdata == $past(ioRegs[aliasIdx]))
        else $error("data-space alias wrong");
    AST_IO_NO_EXT: assert property (taken && !dataOp |=> !ext.valid)
        else $error("I/O op reached extended space");
    AST_EXT_READ: assert property (taken && req.op == IOD_OP_LOAD && req.addr >= 9'h060 |=>
        (ext.valid && !ext.write && ext.addr == $past(req.addr) && !reqReady)
        ##1 (resp.valid && resp.rdata == $past(extRdData) && reqReady))
        else $error("extended load wrong");
    AST_EXT_WRITE: assert property (taken && req.op == IOD_OP_STORE && req.addr >= 9'h060 |=>
        ext.valid && ext.write && ext.addr == $past(req.addr) && ext.wdata == $past(req.wdata))
        else $error("extended store wrong");
    AST_EXT_CAUSE: assert property (ext.valid |-> $past(taken && dataOp && req.addr >= 9'h060))
        else $error("stray extended strobe");
    AST_RESERVED_READ: assert property (taken && req.op == IOD_OP_IN && ioAddr <= 6'h02 |=>
        resp.rdata == 8'h00)
        else $error("reserved address read nonzero");
endmodule

bind iod_decoder iod_decoder_monitor #(.IO_LOCATIONS(IO_LOCATIONS)) mon_u (.clk(clk), .rst(rst), .req(req),
    .reqReady(reqReady), .resp(resp), .hwIn(hwIn), .hwSet(hwSet), .ioRegs(ioRegs), .ext(ext),
    .extRdData(extRdData));

// [tb/testbench.sv]
// Self-checking bench for the I/O space decoder: requests noted in a queue, a watcher compares answers.
// Assumes iod_ext_model serves the extended space and the checker is bound to the decoder.
`timescale 1ns/1ns
module testbench;
    import iod_pkg::*;
    typedef struct packed {logic refused; logic skip; logic [7:0] mask; logic [7:0] rdata;} iod_note_t;
    logic             clk = 1'b0;
    logic             rst;
    iod_req_t         req;
    logic             reqReady;
    iod_resp_t        resp;
    logic [63:0][7:0] hwIn;
    logic [63:0][7:0] hwSet;
    logic [63:0][7:0] ioRegs;
    iod_ext_t         ext;
    logic [7:0]       extRdData;
    iod_note_t        notes[$];
    iod_note_t        note;
    int               mismatches = 0;
    int               compares = 0;
    logic [31:0]      lfsr = 32'h64B1;
    logic [7:0]       v;
    logic [5:0]       plainRegs [8] = '{6'h04, 6'h05, 6'h0A, 6'h0B, 6'h1E, 6'h2A, 6'h2B, 6'h3D};

    iod_decoder #(.IO_LOCATIONS(64)) dut_u (.clk(clk), .rst(rst), .req(req), .reqReady(reqReady),
        .resp(resp), .hwIn(hwIn), .hwSet(hwSet), .ioRegs(ioRegs), .ext(ext), .extRdData(extRdData));
    iod_ext_model ext_u (.clk(clk), .ext(ext), .extRdData(extRdData));

    always #2 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Called at a falling edge; returns at the falling edge after the taking edge, request still up
    task automatic issue(input iod_op_t op, input logic [8:0] a, input logic [2:0] b, input logic [7:0] wd,
                         input logic [7:0] mask, input logic [7:0] exp, input logic skip, input logic refused);
        int n;
        n = 0;
        req <= '{1'b1, op, a, b, wd};
        notes.push_back('{refused, skip, mask, exp});
        while (reqReady !== 1'b1 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        if (n == 50)
        begin
            mismatches++;
            print_verdict();
        end
        @(negedge clk);
    endtask

    task automatic put(input iod_op_t op, input logic [8:0] a, input logic [7:0] wd);
        issue(op, a, 3'h0, wd, 8'h00, 8'h00, 1'b0, 1'b0);
    endtask

    task automatic get(input iod_op_t op, input logic [8:0] a, input logic [7:0] exp);
        issue(op, a, 3'h0, 8'h00, 8'hFF, exp, 1'b0, 1'b0);
    endtask

    task automatic idle();
        req.valid <= 1'b0;
        @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge clk)
        if (resp.valid === 1'b1)
        begin
            if (notes.size() == 0)
                check(32'h1, 32'h0);
            else
            begin
                note = notes.pop_front();
                check({resp.refused, resp.skip, resp.rdata & note.mask},
                      {note.refused, note.skip, note.rdata & note.mask});
            end
        end

    initial
    begin
        repeat (5000) @(posedge clk);
        mismatches++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst = 1'b1;
        req = '0;
        hwIn = '0;
        hwSet = '0;
        repeat (16) @(negedge clk);
        rst <= 1'b0;
        @(negedge clk);
        for (int i = 0; i < 64; i++)
            check(ioRegs[i], 8'h00);
        v = rnd();
        hwIn[3] <= v;
        repeat (2) @(negedge clk);
        get(IOD_OP_IN, 9'h003, v);
        put(IOD_OP_OUT, 9'h003, 8'h00);  // Read-only, mapped, no reserved bits
        get(IOD_OP_LOAD, 9'h023, v);
        foreach (plainRegs[i])
        begin
            v = rnd();
            put(IOD_OP_OUT, {3'h0, plainRegs[i]}, v);
            get(IOD_OP_LOAD, {3'h0, plainRegs[i]} + 9'h020, v);
            v = ~v;
            put(IOD_OP_STORE, {3'h0, plainRegs[i]} + 9'h020, v);
            get(IOD_OP_IN, {3'h0, plainRegs[i]}, v);
        end
        put(IOD_OP_OUT, 9'h008, 8'hFF);  // Reserved bits set on purpose
        get(IOD_OP_IN, 9'h008, 8'hC0);
        get(IOD_OP_IN, 9'h000, 8'h00);
        put(IOD_OP_OUT, 9'h005, 8'hA5);
        issue(IOD_OP_SETBIT, 9'h005, 3'h1, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
        issue(IOD_OP_CLRBIT, 9'h005, 3'h0, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
        get(IOD_OP_IN, 9'h005, 8'hA6);
        v = 8'hA6;
        for (int b = 0; b < 8; b++)
        begin
            issue(IOD_OP_SKIPSET, 9'h005, 3'(b), 8'h00, 8'h00, 8'h00, v[b], 1'b0);
            issue(IOD_OP_SKIPCLR, 9'h005, 3'(b), 8'h00, 8'h00, 8'h00, ~v[b], 1'b0);
        end
        issue(IOD_OP_SETBIT, 9'h025, 3'h0, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1);
        get(IOD_OP_IN, 9'h025, 8'h00);
        issue(IOD_OP_LOAD, 9'h005, 3'h0, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1);
        idle();
        hwSet[21] <= 8'h07;
        @(negedge clk);
        hwSet[21] <= 8'h00;
        @(negedge clk);
        check(ioRegs[21], 8'h07);
        put(IOD_OP_OUT, 9'h015, 8'h01);
        put(IOD_OP_OUT, 9'h015, 8'h00);
        get(IOD_OP_IN, 9'h015, 8'h06);
        issue(IOD_OP_SETBIT, 9'h015, 3'h0, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
        get(IOD_OP_IN, 9'h015, 8'h00);
        v = rnd();
        put(IOD_OP_STORE, 9'h1FF, v);
        get(IOD_OP_LOAD, 9'h1FF, v);
        get(IOD_OP_LOAD, 9'h060, 8'h3A);
        get(IOD_OP_LOAD, 9'h100, 8'h5A);
        // Bits above the six-bit field must not move the access off location 0x05
        get(IOD_OP_IN, 9'h1C5, 8'hA6);
        idle();
        rst <= 1'b1;
        repeat (2) @(negedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check(ioRegs[5], 8'h00);
        get(IOD_OP_IN, 9'h005, 8'h00);
        idle();
        repeat (3) @(negedge clk);
        check(notes.size(), 0);
        print_verdict();
    end
endmodule
